// *** power_switch_ctrl.sv ***
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
module power_switch_ctrl
    import switch_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic global_reset_in_n,
    input wire logic bus_reset_in_n,
    input wire logic suspend_in,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic link_clk,
    input wire logic switch_clk_i,
    output switch_pins_s pins
);

    // ------------------------------------------------------------------
    // Reset release and pin sampling
    // ------------------------------------------------------------------
    logic rst_n;
    logic global_reset_in_n_s;
    logic brst_n_s;
    logic susp_s;
    sync_bit u_rst (.clk(clk), .rst_n(arst_n), .d(1'b1), .q(rst_n));
    sync_bit u_global_reset_in (.clk(clk), .rst_n(rst_n), .d(global_reset_in_n),
        .q(global_reset_in_n_s));
    sync_bit u_brst (.clk(clk), .rst_n(rst_n), .d(bus_reset_in_n),
        .q(brst_n_s));
    sync_bit u_susp (.clk(clk), .rst_n(rst_n), .d(suspend_in), .q(susp_s));

    wire any_reset = !global_reset_in_n_s || !brst_n_s;
    wire clear_all = !global_reset_in_n_s && !susp_s;
    wire clear_some = !brst_n_s && !susp_s;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0] sysctl_reg;
    logic [31:0] sysctl_next;
    logic [WORD_BITS-1:0] pword_reg;
    logic [WORD_BITS-1:0] pword_next;
    logic send_tgl_reg;
    logic send_tgl_next;
    logic [31:0] rdata_next;
    logic busy_seen;
    logic pin_clk_seen;

    wire hit_sys = addr == SYSTEM_CONTROL_ADDR;
    wire hit_word = addr == POWER_WORD_ADDR;
    wire hit_stat = addr == LINK_STATUS_ADDR;
    wire bus_ok = !any_reset;
    wire wr_sys = wr && bus_ok && hit_sys;
    wire wr_word = wr && bus_ok && hit_word;
    wire rd_ok = rd && bus_ok;
    wire clk_dir = sysctl_reg[CLK_DIR_BIT];

    assign sysctl_next = wr_sys ? (wdata & SYSTEM_CONTROL_MASK) : sysctl_reg;
    assign pword_next = wr_word ? wdata[WORD_BITS-1:0] : pword_reg;
    assign send_tgl_next = wr_word ? !send_tgl_reg : send_tgl_reg;
    assign rdata_next = !rd_ok ? 32'h0000_0000 :
        hit_sys ? sysctl_reg :
        hit_word ? {{(32-WORD_BITS){1'b0}}, pword_reg} :
        hit_stat ? {30'h0000_0000, pin_clk_seen, busy_seen} : 32'h0000_0000;

    // System control is cleared only by global reset without suspend.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sysctl_reg <= SYSTEM_CONTROL_RESET;
        end else if (clear_all) begin
            sysctl_reg <= SYSTEM_CONTROL_RESET;
        end else begin
            sysctl_reg <= sysctl_next;
        end
    end

    // The power word and read path are cleared by either reset without suspend.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pword_reg <= POWER_WORD_RESET;
            rdata <= 32'h0000_0000;
        end else if (clear_all || clear_some) begin
            pword_reg <= POWER_WORD_RESET;
            rdata <= 32'h0000_0000;
        end else begin
            pword_reg <= pword_next;
            rdata <= rdata_next;
        end
    end

    // The send toggle never resets except at power up so domains agree.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            send_tgl_reg <= 1'b0;
        end else begin
            send_tgl_reg <= send_tgl_next;
        end
    end

    // ------------------------------------------------------------------
    // Crossing between the host and link domains
    // ------------------------------------------------------------------
    logic float_reg;
    logic lrst_n;
    logic tgl_l;

    // The float request leaves this domain from a flip-flop, not a gate.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            float_reg <= 1'b1;
        end else begin
            float_reg <= any_reset;
        end
    end

    logic float_l;
    logic dir_l;
    logic busy_reg;
    sync_bit u_lrst (.clk(link_clk), .rst_n(arst_n), .d(1'b1), .q(lrst_n));
    sync_bit u_ltgl (.clk(link_clk), .rst_n(lrst_n), .d(send_tgl_reg),
        .q(tgl_l));
    sync_bit u_lflt (.clk(link_clk), .rst_n(lrst_n), .d(float_reg),
        .q(float_l));
    sync_bit u_ldir (.clk(link_clk), .rst_n(lrst_n), .d(clk_dir),
        .q(dir_l));
    sync_bit u_busy (.clk(clk), .rst_n(rst_n), .d(busy_reg),
        .q(busy_seen));
    // The switch clock pin level is readable whether driven or not.
    sync_bit u_pclk (.clk(clk), .rst_n(rst_n), .d(switch_clk_i),
        .q(pin_clk_seen));

    // ------------------------------------------------------------------
    // Serial shifter on the link clock
    // ------------------------------------------------------------------
    shift_state_e st_reg;
    shift_state_e st_next;
    logic [WORD_BITS-1:0] sh_reg;
    logic [WORD_BITS-1:0] sh_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [15:0] div_reg;
    logic [15:0] div_next;
    logic sclk_reg;
    logic sclk_next;
    logic seen_tgl_reg;
    logic [WORD_BITS-1:0] word_l;
    word_xfer_s xfer;
    switch_pins_s pins_next;

    // The word is stable for the whole send because the shifter copies it at start.
    assign xfer = '{word: pword_reg, toggle: send_tgl_reg};
    assign word_l = xfer.word;
    wire start = tgl_l != seen_tgl_reg;
    wire div_end = div_reg == DIV_HALF;
    wire rise = div_end && !sclk_reg;
    wire fall = div_end && sclk_reg;

    always_comb begin
        st_next = st_reg;
        sh_next = sh_reg;
        cnt_next = cnt_reg;
        div_next = div_end ? 16'h0000 : div_reg + 16'h0001;
        sclk_next = div_end ? !sclk_reg : sclk_reg;
        unique case (st_reg)
            SH_IDLE: begin
                sclk_next = 1'b0;
                div_next = 16'h0000;
                if (start) begin
                    st_next = SH_SHIFT;
                    sh_next = word_l;
                    cnt_next = '0;
                end
            end
            SH_SHIFT: begin
                if (fall) begin
                    sh_next = {sh_reg[WORD_BITS-2:0], 1'b0};
                    if (cnt_reg == LAST_BIT) begin
                        st_next = SH_LATCH;
                    end else begin
                        cnt_next = cnt_reg + 5'h01;
                    end
                end
            end
            SH_LATCH: begin
                sclk_next = 1'b0;
                if (div_end) begin
                    st_next = SH_IDLE;
                end
            end
        endcase
    end

    always_comb begin
        pins_next.clk_o = sclk_reg;
        pins_next.clk_oe = dir_l && !float_l;
        pins_next.data_o = sh_reg[WORD_BITS-1];
        pins_next.data_oe = !float_l;
        pins_next.latch_o = st_reg == SH_LATCH;
        pins_next.latch_oe = !float_l;
    end

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            st_reg <= SH_IDLE;
            sh_reg <= '0;
            cnt_reg <= '0;
            div_reg <= 16'h0000;
            sclk_reg <= 1'b0;
            seen_tgl_reg <= 1'b0;
            busy_reg <= 1'b0;
            pins <= '0;
        end else begin
            st_reg <= st_next;
            sh_reg <= sh_next;
            cnt_reg <= cnt_next;
            div_reg <= div_next;
            sclk_reg <= sclk_next;
            seen_tgl_reg <= start && st_reg == SH_IDLE ? tgl_l : seen_tgl_reg;
            busy_reg <= st_next != SH_IDLE;
            pins <= pins_next;
        end
    end

endmodule : power_switch_ctrl

// *** switch_pkg.sv ***
// Summary of operation
// - Switch clock pin is an input after reset; bit 27 makes it an output.
// - Power control settings leave one bit at a time on the data line.
// - Latch is asserted once the shifted word is complete and valid.
// - Global reset without suspend floats outputs and clears all registers.
// - Under suspend, global reset keeps registers but still floats outputs.
// - Bus reset floats outputs and clears only some registers.
// - No function during bus reset; default operating state after release.
// - Suspend with bus reset keeps all registers and floats all outputs.
// - Host bus signals are sampled on the rising edge of the bus clock.
package switch_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] SYSTEM_CONTROL_ADDR = 8'h80;
    localparam logic [7:0] POWER_WORD_ADDR = 8'h84;
    localparam logic [7:0] LINK_STATUS_ADDR = 8'h88;
    localparam int CLK_DIR_BIT = 27;
    localparam logic [31:0] SYSTEM_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] SYSTEM_CONTROL_MASK = 32'hffff_ffff;

    // ------------------------------------------------------------------
    // Power switch word
    // ------------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] LAST_BIT = 5'h0f;
    localparam logic [15:0] POWER_WORD_RESET = 16'h0000;
    localparam logic [15:0] DIV_HALF = 16'h0003;

    typedef struct packed {
        logic [WORD_BITS-1:0] word;
        logic toggle;
    } word_xfer_s;

    typedef struct packed {
        logic clk_o;
        logic clk_oe;
        logic data_o;
        logic data_oe;
        logic latch_o;
        logic latch_oe;
    } switch_pins_s;

    typedef enum logic [1:0] {
        SH_IDLE,
        SH_SHIFT,
        SH_LATCH
    } shift_state_e;

endpackage : switch_pkg

// *** sync_bit.sv ***
`timescale 1ns/100ps
module sync_bit (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : sync_bit

// *** switch_chk.sv ***
`timescale 1ns/100ps
module switch_chk
    import switch_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic global_reset_in_n,
    input wire logic bus_reset_in_n,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic link_clk,
    input switch_pins_s pins
);
    property p_rd_idle; @(posedge clk) disable iff (!arst_n)
        !$past(rd) |-> rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
    property p_global_reset_in_float; @(posedge link_clk) disable iff (!arst_n)
        !global_reset_in_n [*8] |-> !(pins.clk_oe | pins.data_oe | pins.latch_oe);
    endproperty
    a_global_reset_in_float: assert property (p_global_reset_in_float)
        else $error("pins driven in global reset");
    property p_brst_float; @(posedge link_clk) disable iff (!arst_n)
        !bus_reset_in_n [*8] |-> !(pins.clk_oe | pins.data_oe | pins.latch_oe);
    endproperty
    a_brst_float: assert property (p_brst_float)
        else $error("pins driven in bus reset");
    property p_latch_hold; @(posedge link_clk) disable iff (!arst_n)
        pins.latch_o && $past(pins.latch_o) |-> $stable(pins.data_o); endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("data moved under latch");
    property p_data_fall; @(posedge link_clk) disable iff (!arst_n)
        $changed(pins.data_o) |-> !pins.clk_o; endproperty
    a_data_fall: assert property (p_data_fall)
        else $error("data moved while clock high");
    property p_latch_clk; @(posedge link_clk) disable iff (!arst_n)
        pins.latch_o |-> !pins.clk_o; endproperty
    a_latch_clk: assert property (p_latch_clk)
        else $error("clock high during latch");
    property p_latch_w; @(posedge link_clk) disable iff (!arst_n)
        $rose(pins.latch_o) |-> pins.latch_o [*4] ##1 !pins.latch_o; endproperty
    a_latch_w: assert property (p_latch_w)
        else $error("latch width wrong");
    property p_clk_half; @(posedge link_clk) disable iff (!arst_n)
        $rose(pins.clk_o) |-> pins.clk_o [*4] ##1 !pins.clk_o; endproperty
    a_clk_half: assert property (p_clk_half)
        else $error("switch clock half period wrong");
endmodule : switch_chk
bind power_switch_ctrl switch_chk chk_i (.clk(clk), .arst_n(arst_n),
    .global_reset_in_n(global_reset_in_n), .bus_reset_in_n(bus_reset_in_n),
    .rd(rd), .rdata(rdata), .link_clk(link_clk), .pins(pins));

// *** switch_model.sv ***
`timescale 1ns/100ps
module switch_model (
    input wire logic sclk,
    input wire logic sdata,
    input wire logic slatch,
    output logic [15:0] word,
    output int nbits,
    output int nlatch
);
    logic [15:0] sh;
    initial begin
        sh = 16'h0;
        word = 16'h0;
        nbits = 0;
        nlatch = 0;
    end
    always @(posedge sclk) begin
        sh <= {sh[14:0], sdata};
        nbits <= nbits + 1;
    end
    always @(posedge slatch) begin
        word <= sh;
        nlatch <= nlatch + 1;
    end
endmodule : switch_model

// *** tb_top.sv ***
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
    import switch_pkg::*;
    logic clk = 1'h0, link_clk = 1'h0, arst_n = 1'h0;
    logic g_n = 1'h0, b_n = 1'h1, susp = 1'h0, wr = 1'h0, rd = 1'h0;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, sc;
    logic [15:0] m_word, pw;
    switch_pins_s pins;
    int m_bits, m_latch, n_mismatch = 0, cmp_count = 0, n;
    // Board pull-downs hold undriven switch lines low.
    wire sw_clk = pins.clk_oe & pins.clk_o;
    wire sw_data = pins.data_oe & pins.data_o;
    wire sw_latch = pins.latch_oe & pins.latch_o;
    initial forever #4 clk = ~clk;
    initial begin
        #3;
        forever #15 link_clk = ~link_clk;
    end
    power_switch_ctrl dut (.clk(clk), .arst_n(arst_n),
        .global_reset_in_n(g_n), .bus_reset_in_n(b_n), .suspend_in(susp),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .link_clk(link_clk), .switch_clk_i(sw_clk), .pins(pins));
    switch_model m (.sclk(sw_clk), .sdata(sw_data), .slatch(sw_latch),
        .word(m_word), .nbits(m_bits), .nlatch(m_latch));
    task finish_test;
        $display("Compared %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask : wr_reg
    task rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 d = rdata;
    endtask : rd_reg
    task chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd_reg(a, d);
        `CHK("rdata", e, d)
    endtask : chk
    task send(input logic [15:0] w);
        int n0;
        logic [31:0] d;
        n0 = m_latch;
        wr_reg(8'h84, {16'h0, w});
        for (int k = 0; k < 4000 && m_latch == n0; k++) @(posedge clk);
        `CHK("latch", n0 + 1, m_latch)
        if (m_latch == n0) finish_test();
        d = 32'h1;
        for (int k = 0; k < 50 && d[0]; k++) rd_reg(8'h88, d);
        `CHK("busy", 1'h0, d[0])
        if (d[0]) finish_test();
    endtask : send
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'h1;
        repeat (2) @(posedge clk);
        g_n <= 1'h1;
        repeat (4) @(posedge clk);
        chk(8'h80, 32'h0);
        chk(8'h84, 32'h0);
        wr_reg(8'h8c, 32'h1234_5678);
        chk(8'h8c, 32'h0);
        chk(8'h88, 32'h0);
        `CHK("clk_oe", 1'h0, pins.clk_oe)
        $display("test regs done");
        wr_reg(8'h80, 32'h0800_0001);
        chk(8'h80, 32'h0800_0001);
        n = m_bits;
        send(16'ha5c3);
        `CHK("clk_oe", 1'h1, pins.clk_oe)
        `CHK("word", 16'ha5c3, m_word)
        `CHK("bits", 32'h10, m_bits - n)
        send(16'h8001);
        `CHK("word", 16'h8001, m_word)
        wr_reg(8'h80, 32'h0);
        n = m_bits;
        send(16'h7ffe);
        `CHK("bits", 32'h0, m_bits - n)
        $display("test link done");
        for (int i = 0; i < 4; i++) begin
            sc = 32'h0800_0000 | i;
            pw = 16'h1100 | i[15:0];
            wr_reg(8'h80, sc);
            send(pw);
            susp <= i[1];
            repeat (4) @(posedge clk);
            if (i[0]) g_n <= 1'h0;
            else b_n <= 1'h0;
            repeat (40) @(posedge clk);
            chk(8'h80, 32'h0);
            wr_reg(8'h84, 32'hffff);
            g_n <= 1'h1;
            b_n <= 1'h1;
            repeat (40) @(posedge clk);
            susp <= 1'h0;
            repeat (4) @(posedge clk);
            chk(8'h80, (i == 1) ? 32'h0 : sc);
            chk(8'h84, i[1] ? {16'h0, pw} : 32'h0);
            $display("test reset %0d done", i);
        end
        g_n <= 1'h0;
        b_n <= 1'h0;
        repeat (40) @(posedge clk);
        g_n <= 1'h1;
        b_n <= 1'h1;
        repeat (40) @(posedge clk);
        chk(8'h80, 32'h0);
        chk(8'h84, 32'h0);
        $display("test shared reset done");
        finish_test();
    end
endmodule : tb_top
